// ### logic/drs_refresh.sv
// Contract
// - Refresh decodes with select and both strobes low, write and clock enable high.
// - Refresh rows come from internal counter; external address ignored.
// - After refresh cycle completes, all banks are precharged idle.
// - Self-refresh entry decodes like refresh but with clock enable low.
// - Loop disabled on entry, re-enabled with reset on exit when enabled.
// - In self-refresh, ignore all controls but clock enable and reset.
// - Start one internal refresh within min pulse, then own timer.
`timescale 1ns/1ps
`default_nettype none
module drs_refresh
    import drs_pkg::*;
#(
    parameter int SELF_INTERVAL = SELF_INTERVAL_CYCLES
) (
    input wire logic clk, // System clock
    input wire logic rst, // Synchronous reset, high
    input wire drs_cmd_pins_t cmd_pins, // Command pins from outside
    input wire logic [ROW_W-1:0] addr_pins, // External address, unused here
    input wire logic loop_disable, // Mode register one loop disable bit
    output logic bank_idle_ff, // All banks precharged idle
    output logic refresh_busy_ff, // Internal refresh cycle running
    output logic [ROW_W-1:0] refresh_row_ff, // Row being refreshed
    output logic self_refresh_ff, // Device in self-refresh
    output logic loop_enable_ff, // Delay locked loop running
    output logic loop_reset_ff, // One-cycle loop reset pulse
    output logic int_clk_en_ff // Internal clock gate
);
    // Elaboration checks: the self timer must outlast a refresh and fit its counter
    if (SELF_INTERVAL < REFRESH_CYCLES + 1) begin : g_short_interval
        $error("SELF_INTERVAL too short for a refresh cycle");
    end
    if (SELF_INTERVAL > (1 << CNT_W)) begin : g_long_interval
        $error("SELF_INTERVAL does not fit the cycle counter");
    end

    // Pin synchronisers, two stages
    drs_cmd_pins_t pins_s1_ff, pins_ff;
    always_ff @(posedge clk) begin
        if (rst) begin
            pins_s1_ff <= '{default: 1'b1};
            pins_ff <= '{default: 1'b1};
        end else begin
            pins_s1_ff <= cmd_pins;
            pins_ff <= pins_s1_ff;
        end
    end

    // Command decode; clock_enable low at entry selects self-refresh
    wire ref_shape = !pins_ff.chip_select_n && !pins_ff.row_strobe_n
                     && !pins_ff.column_strobe_n && pins_ff.write_enable_n;
    wire refresh_cmd = ref_shape && pins_ff.clock_enable;
    wire self_entry_cmd = ref_shape && !pins_ff.clock_enable;

    drs_state_t state_ff, nxt_state;
    logic [CNT_W-1:0] cyc_ff, nxt_cyc;
    logic [CNT_W-1:0] timer_ff, nxt_timer;
    logic [CNT_W-1:0] stay_ff, nxt_stay;
    logic sr_pending_ff, nxt_sr_pending;
    wire refresh_done = (state_ff == ST_REFRESH) && (cyc_ff == CNT_W'(REFRESH_CYCLES - 1));
    // Exit only once the minimum stay has passed; earlier CKE rise is held off
    wire exit_ok = pins_ff.clock_enable && (stay_ff >= CNT_W'(CKE_MIN_CYCLES));
    wire timer_fire = (timer_ff == CNT_W'(SELF_INTERVAL - 1));

    // Refresh and self-refresh sequencer
    always_comb begin
        nxt_state = state_ff;
        nxt_cyc = cyc_ff;
        nxt_timer = timer_ff;
        nxt_stay = stay_ff;
        nxt_sr_pending = sr_pending_ff;
        case (state_ff)
            ST_IDLE: begin
                if (refresh_cmd) begin
                    nxt_state = ST_REFRESH;
                    nxt_cyc = '0;
                end else if (self_entry_cmd) begin
                    nxt_state = ST_REFRESH;
                    nxt_cyc = '0;
                    nxt_sr_pending = 1'b1;
                    nxt_timer = '0;
                    nxt_stay = '0;
                end
            end
            ST_REFRESH: begin
                nxt_cyc = cyc_ff + CNT_W'(1);
                if (sr_pending_ff) begin
                    nxt_timer = timer_ff + CNT_W'(1);
                    if (stay_ff != '1)
                        nxt_stay = stay_ff + CNT_W'(1);
                end
                if (refresh_done)
                    nxt_state = sr_pending_ff ? ST_SELF : ST_IDLE;
            end
            ST_SELF: begin
                // only clock enable is looked at here
                if (stay_ff != '1)
                    nxt_stay = stay_ff + CNT_W'(1);
                nxt_timer = timer_ff + CNT_W'(1);
                if (exit_ok) begin
                    nxt_state = ST_IDLE;
                    nxt_sr_pending = 1'b0;
                end else if (timer_fire) begin
                    nxt_state = ST_REFRESH;
                    nxt_cyc = '0;
                    nxt_timer = '0;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= ST_IDLE;
            cyc_ff <= '0;
            timer_ff <= '0;
            stay_ff <= '0;
            sr_pending_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cyc_ff <= nxt_cyc;
            timer_ff <= nxt_timer;
            stay_ff <= nxt_stay;
            sr_pending_ff <= nxt_sr_pending;
        end
    end

    // Row counter advances per completed refresh
    wire nxt_busy = (nxt_state == ST_REFRESH);
    wire in_self = sr_pending_ff;
    wire self_entering = (state_ff == ST_IDLE) && self_entry_cmd;
    wire self_leaving = (state_ff == ST_SELF) && exit_ok;
    always_ff @(posedge clk) begin
        if (rst) begin
            refresh_row_ff <= '0;
            refresh_busy_ff <= 1'b0;
            bank_idle_ff <= 1'b1;
            self_refresh_ff <= 1'b0;
            int_clk_en_ff <= 1'b1;
        end else begin
            if (refresh_done)
                refresh_row_ff <= refresh_row_ff + ROW_W'(1);
            refresh_busy_ff <= nxt_busy;
            bank_idle_ff <= !nxt_busy;
            self_refresh_ff <= nxt_sr_pending;
            int_clk_en_ff <= !(nxt_sr_pending && !nxt_busy);
        end
    end

    // Loop control: off on entry, back on with reset pulse on exit
    always_ff @(posedge clk) begin
        if (rst) begin
            loop_enable_ff <= 1'b0;
            loop_reset_ff <= 1'b0;
        end else begin
            loop_reset_ff <= self_leaving && !loop_disable;
            if (self_entering || in_self)
                loop_enable_ff <= 1'b0;
            else if (!loop_disable)
                loop_enable_ff <= 1'b1;
            else
                loop_enable_ff <= 1'b0;
        end
    end

    // busy at the edge after decode
    refresh_start_a: assert property (@(posedge clk) disable iff (rst)
        (state_ff == ST_IDLE && refresh_cmd) |=> refresh_busy_ff)
        else $error("refresh not started");
    // row counter steps once per refresh
    row_step_a: assert property (@(posedge clk) disable iff (rst)
        refresh_done |=> refresh_row_ff == $past(refresh_row_ff) + ROW_W'(1))
        else $error("row counter did not step");
    bank_idle_a: assert property (@(posedge clk) disable iff (rst)
        (refresh_done && !sr_pending_ff) |=> bank_idle_ff && !refresh_busy_ff)
        else $error("banks not idle after refresh");
    self_entry_a: assert property (@(posedge clk) disable iff (rst)
        self_entering |=> self_refresh_ff && refresh_busy_ff)
        else $error("self-refresh entry missed");
    loop_reset_a: assert property (@(posedge clk) disable iff (rst)
        (self_leaving && !loop_disable) |=> loop_reset_ff ##1 loop_enable_ff)
        else $error("loop not reset on exit");
    clk_gate_a: assert property (@(posedge clk) disable iff (rst)
        (state_ff == ST_SELF && self_refresh_ff && !refresh_busy_ff) |-> !int_clk_en_ff)
        else $error("internal clock not gated");
    // a refresh runs right after entry
    first_refresh_a: assert property (@(posedge clk) disable iff (rst)
        self_entering |=> refresh_busy_ff [*2])
        else $error("no refresh on entry");
    ignore_cmds_a: assert property (@(posedge clk) disable iff (rst)
        (state_ff == ST_SELF && !exit_ok && !timer_fire) |=> state_ff == ST_SELF)
        else $error("command acted on in self-refresh");
endmodule : drs_refresh
`default_nettype wire

// ### logic/drs_pkg.sv
package drs_pkg;
    // Row address width of the internal refresh counter
    localparam int ROW_W = 16;
    // Timing figures in ns
    localparam int CLK_PERIOD_NS = 8;
    localparam int REFRESH_CYCLE_NS = 160;
    localparam int CKE_MIN_PULSE_NS = 5;
    localparam int SELF_REFRESH_INTERVAL_NS = 7800;
    // Cycle counts: refresh cycle rounds up; CKE minimum and longest times round down, CKE kept at least 1
    localparam int REFRESH_CYCLES = (REFRESH_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CKE_MIN_CYCLES_RAW = CKE_MIN_PULSE_NS / CLK_PERIOD_NS;
    localparam int CKE_MIN_CYCLES = (CKE_MIN_CYCLES_RAW < 1) ? 1 : CKE_MIN_CYCLES_RAW;
    localparam int SELF_INTERVAL_CYCLES = SELF_REFRESH_INTERVAL_NS / CLK_PERIOD_NS;
    localparam int CNT_W = 16;
    // Mode register one field: loop disable bit
    localparam int MR1_LOOP_DIS_BIT = 0;

    // Command pins sampled on a rising edge
    typedef struct packed {
        logic chip_select_n;
        logic row_strobe_n;
        logic column_strobe_n;
        logic write_enable_n;
        logic clock_enable;
    } drs_cmd_pins_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_REFRESH,
        ST_SELF
    } drs_state_t;
endpackage : drs_pkg

// ### bench/drs_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// Controller side: one command per request except a held-back ninth refresh pull-in, deselect in between
module drs_ctrl_model
    import drs_pkg::*;
#(
    parameter int INTERVAL = SELF_INTERVAL_CYCLES // Average refresh spacing, cycles
) (
    input wire logic clk, // System clock
    input wire logic rst, // Sync reset, high
    input wire logic req, // Issue cmd at this edge
    input wire drs_cmd_pins_t cmd, // Pin pattern to issue
    output var drs_cmd_pins_t pins // Pins toward the device
);
    localparam int CREDIT_MAX = 8;
    int credit_ff;
    int tick_ff;
    int credit_sum;
    // Refresh pattern in the request
    wire is_ref = !cmd.chip_select_n && !cmd.row_strobe_n && !cmd.column_strobe_n
                  && cmd.write_enable_n && cmd.clock_enable;
    wire tick = (tick_ff == INTERVAL - 1);
    // a ninth pull-in earns nothing, so it is held back
    wire send = req && !(is_ref && credit_ff >= CREDIT_MAX);
    // credit: advanced above zero, owed below
    assign credit_sum = credit_ff + ((send && is_ref) ? 1 : 0) - (tick ? 1 : 0);

    // deselect, hold enable
    // Clock enable is kept from the last command so a park stays parked
    always_ff @(posedge clk) begin
        if (rst) begin
            pins <= 5'h1f;
            tick_ff <= 0;
            credit_ff <= 0;
        end else begin
            if (send) begin
                pins <= cmd;
            end else begin
                pins <= {4'hf, pins.clock_enable};
            end
            tick_ff <= tick ? 0 : tick_ff + 1;
            // every interval owes one more refresh, until eight are owed
            credit_ff <= (credit_sum < -CREDIT_MAX) ? -CREDIT_MAX : credit_sum;
        end
    end
endmodule : drs_ctrl_model
`default_nettype wire

// ### bench/dram_refresh_self_refresh_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module dram_refresh_self_refresh_tb_top;
    import drs_pkg::*;
    // Pin pattern and whether it should start a refresh cycle
    typedef struct packed {
        drs_cmd_pins_t c;
        logic busy;
    } drs_row_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic req = 1'b0;
    logic loop_dis = 1'b0;
    logic bprev = 1'b0;
    logic [ROW_W-1:0] addr = 16'h0000;
    drs_cmd_pins_t cmd = 5'h1f;
    drs_cmd_pins_t pins;
    logic idle, busy, self_on, loop_en, loop_rst, clk_en;
    logic [ROW_W-1:0] row;
    int error_cnt = 0;
    int checked = 0;
    int nrise = 0;
    int nfall = 0;
    int n, k;
    int nbase = 0;
    // Short exit wait: a plain default, one refresh cycle plus margin
    localparam int EXIT_SHORT_CYC = REFRESH_CYCLES + 2;
    drs_row_t rows [4] = '{'{5'h03, 1'b1}, '{5'h01, 1'b0}, '{5'h13, 1'b0}, '{5'h07, 1'b0}};

    always #4 clk = ~clk;

    drs_ctrl_model ctl (.clk(clk), .rst(rst), .req(req), .cmd(cmd), .pins(pins));
    drs_refresh #(.SELF_INTERVAL(40)) uut (.clk(clk), .rst(rst), .cmd_pins(pins),
        .addr_pins(addr), .loop_disable(loop_dis), .bank_idle_ff(idle),
        .refresh_busy_ff(busy), .refresh_row_ff(row), .self_refresh_ff(self_on),
        .loop_enable_ff(loop_en), .loop_reset_ff(loop_rst), .int_clk_en_ff(clk_en));

    // Count refresh cycles seen, settled on the falling edge
    always @(negedge clk) begin
        bprev <= busy;
        if (busy === 1'b1 && bprev === 1'b0) nrise++;
        if (busy === 1'b0 && bprev === 1'b1) nfall++;
    end

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    // Address flips with every command; the device must not care
    task automatic issue(input drs_cmd_pins_t c);
        @(posedge clk);
        req <= 1'b1;
        cmd <= c;
        addr <= ~addr;
        @(posedge clk);
        req <= 1'b0;
    endtask : issue

    task automatic do_ref(input drs_row_t r);
        int len;
        len = 0;
        issue(r.c);
        n = 0;
        while (busy !== 1'b1 && n < 8) begin @(negedge clk); n++; end
        chk("refresh start", 16'(r.busy), 16'(busy));
        if (busy === 1'b1) begin
            chk("idle in cycle", 16'h0000, 16'(idle));
            // next command waits out the cycle
            while (busy === 1'b1 && len < 40) begin @(negedge clk); len++; end
            chk("cycle length", 16'(REFRESH_CYCLES), 16'(len));
            @(negedge clk);
            chk("idle after", 16'h0001, 16'(idle));
            chk("row step", 16'(nfall - nbase), row);
        end
    endtask : do_ref

    task automatic end_of_test();
        if (error_cnt == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test

    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        repeat (3000) @(posedge clk);
        error_cnt++;
        end_of_test();
    end

    // Reset held for three edges, outputs checked while it is held
    task automatic apply_reset();
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("reset row", 16'h0000, row);
        chk("reset flags", 16'h0011, {11'h0, idle, busy, self_on, loop_rst, clk_en});
        chk("reset loop", 16'h0000, 16'(loop_en));
        @(posedge clk);
        rst <= 1'b0;
        nbase = nfall;
    endtask : apply_reset

    initial begin
        apply_reset();
        for (int i = 0; i < 4; i++) do_ref(rows[i]);
        chk("loop on", 16'h0001, 16'(loop_en));
        // entry only from idle, nothing owed
        // Park with the loop running, then send a pattern that must be ignored
        k = nrise;
        issue(5'h02);
        n = 0;
        while (self_on !== 1'b1 && n < 8) begin @(negedge clk); n++; end
        chk("self entry", 16'h0001, 16'(self_on));
        chk("first refresh", 16'h0001, 16'(busy));
        chk("loop off", 16'h0000, 16'(loop_en));
        issue(5'h00);
        repeat (100) @(negedge clk);
        chk("self held", 16'h0001, 16'(self_on));
        chk("own timer", 16'h0001, 16'(nrise - k >= 2));
        n = 0;
        while (busy !== 1'b0 && n < 30) begin @(negedge clk); n++; end
        chk("clock gated", 16'h0000, 16'(clk_en));
        // Exit may wait for a running internal refresh
        issue(5'h1f);
        n = 0;
        while (self_on !== 1'b0 && n < 40) begin @(negedge clk); n++; end
        chk("exit flags", 16'h0003, {14'h0, loop_rst, clk_en});
        @(negedge clk);
        chk("loop back", 16'h0002, {14'h0, loop_en, loop_rst});
        // deselects through the short wait, then one refresh
        repeat (EXIT_SHORT_CYC) @(negedge clk);
        do_ref('{5'h03, 1'b1});
        // Loop disabled: parked and back with no loop reset pulse
        @(posedge clk);
        loop_dis <= 1'b1;
        issue(5'h02);
        n = 0;
        while (self_on !== 1'b1 && n < 8) begin @(negedge clk); n++; end
        chk("self entry off", 16'h0001, 16'(self_on));
        chk("loop stays off", 16'h0000, 16'(loop_en));
        issue(5'h1f);
        n = 0;
        while (self_on !== 1'b0 && n < 40) begin @(negedge clk); n++; end
        chk("exit no reset", 16'h0001, {14'h0, loop_rst, clk_en});
        @(negedge clk);
        chk("loop still off", 16'h0000, {14'h0, loop_en, loop_rst});
        repeat (EXIT_SHORT_CYC) @(negedge clk);
        // Reset in mid-refresh: all back to idle, rows restart from zero
        issue(5'h03);
        repeat (6) @(negedge clk);
        @(posedge clk);
        apply_reset();
        do_ref(rows[0]);
        end_of_test();
    end
endmodule : dram_refresh_self_refresh_tb_top
`default_nettype wire
